// file: pkg/swm_pkg.sv
package swm_pkg;
  localparam int unsigned CLK_MHZ = 250;

  // link timing limits, microseconds
  localparam int unsigned T_SLOT_MIN_US = 60;
  localparam int unsigned T_SLOT_MAX_US = 120;
  localparam int unsigned T_WSTRB_MAX_US = 15;
  localparam int unsigned T_WDH_MIN_US = 60;
  localparam int unsigned T_REC_MEM_US = 5;
  localparam int unsigned T_RSTRB_MAX_US = 13;
  localparam int unsigned T_ODH_MIN_US = 17;
  localparam int unsigned T_ODH_MAX_US = 60;
  localparam int unsigned T_RST_US = 480;
  localparam int unsigned T_RSTREC_US = 480;
  localparam int unsigned T_PPD_MAX_US = 60;
  localparam int unsigned T_EPROG_US = 2500;
  localparam int unsigned T_PSU_US = 5;
  localparam int unsigned T_PREC_US = 5;

  // operating points inside those limits, microseconds
  localparam int unsigned T_DEV_SAMP_US = 30;
  localparam int unsigned T_DEV_HOLD_US = 30;
  localparam int unsigned T_DEV_PPD_US = 30;
  localparam int unsigned T_DEV_PP_US = 120;
  localparam int unsigned T_HOST_SLOT_US = 70;
  localparam int unsigned T_HOST_WL1_US = 5;
  localparam int unsigned T_HOST_WL0_US = 65;
  localparam int unsigned T_HOST_RL_US = 2;
  localparam int unsigned T_HOST_RSAMP_US = 10;
  localparam int unsigned T_HOST_PSAMP_US = 70;

  // cycle counts; every figure is a whole number of cycles at 250 MHz
  localparam int unsigned C_DEV_SAMP = T_DEV_SAMP_US * CLK_MHZ;
  localparam int unsigned C_DEV_HOLD = T_DEV_HOLD_US * CLK_MHZ;
  localparam int unsigned C_DEV_PPD = T_DEV_PPD_US * CLK_MHZ;
  localparam int unsigned C_DEV_PP = T_DEV_PP_US * CLK_MHZ;
  localparam int unsigned C_RST = T_RST_US * CLK_MHZ;
  localparam int unsigned C_RSTREC = T_RSTREC_US * CLK_MHZ;
  localparam int unsigned C_DEV_PROG = (T_PSU_US + T_EPROG_US) * CLK_MHZ;
  localparam int unsigned C_HOST_PROG =
    (T_PSU_US + T_EPROG_US + T_PREC_US) * CLK_MHZ;
  localparam int unsigned C_HOST_SLOT = T_HOST_SLOT_US * CLK_MHZ;
  localparam int unsigned C_HOST_WL1 = T_HOST_WL1_US * CLK_MHZ;
  localparam int unsigned C_HOST_WL0 = T_HOST_WL0_US * CLK_MHZ;
  localparam int unsigned C_HOST_RL = T_HOST_RL_US * CLK_MHZ;
  localparam int unsigned C_HOST_RSAMP = T_HOST_RSAMP_US * CLK_MHZ;
  localparam int unsigned C_HOST_PSAMP = T_HOST_PSAMP_US * CLK_MHZ;

  // command bytes
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_SKIP_ID = 8'hCC;
  localparam logic [7:0] CMD_READ_MEM = 8'hC3;
  localparam logic [7:0] CMD_WRITE_BUF = 8'h0F;
  localparam logic [7:0] CMD_PROGRAM = 8'h5A;
  localparam logic [7:0] CMD_PROFILE = 8'h99;

  // memory layout
  localparam int unsigned MEM_BYTES = 128;
  localparam int unsigned BUF_BYTES = 8;
  localparam logic [4:0] PAGE_LAST = 5'h1F;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // x^8 + x^5 + x^4 + 1, bit-reversed for lsb-first shifting
  localparam logic [7:0] CRC_POLY_REV = 8'h8C;

  typedef enum logic [1:0] {HC_RESET, HC_WRITE, HC_READ, HC_PROG} swm_hcmd_t;

  function automatic logic [7:0] crc_bit(input logic [7:0] c,
                                         input logic b);
    crc_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY_REV) : (c >> 1);
  endfunction
endpackage

// file: pkg/swm_link_if.sv
interface swm_link_if;
  logic line;
  logic dev_out;
  logic dev_oe_n;
  logic host_out;
  logic host_oe_n;

  // open-drain wire with pull-up: low while any enabled driver pulls low
  assign line = !((!dev_oe_n && !dev_out) || (!host_oe_n && !host_out));

  modport dev (input line, output dev_out, output dev_oe_n);
  modport host (input line, output host_out, output host_oe_n);
endinterface

// file: src/swm_dev_end.sv
// Contract
// [R01] bit slot lasts 60 to 120 us
// [R02] host write start low 1 to 15 us
// [R03] host write level valid by 15 us
// [R04] host holds write level 60 us, below slot
// [R05] host recovery high 1 us, 5 us memory
// [R06] host read start low 1 to 13 us
// [R07] device drives read bit by 13 us
// [R08] device holds low bit 17 to 60 us
// [R09] 480 us reset, presence after 15-60 us
// [R10] host programming 2500 us, 5 us margins
// [R11] 64-bit id: family, serial, crc
// [R12] four 32-byte pages at 00-7F
// [R13] writes land in 8-byte scratch buffer
// [R14] device returns crc of filled buffer
// [R15] program commits buffer to selected segment
// [R16] readable programming-profile byte
// [R17] crc polynomial x8+x5+x4+1, host checks
// [R18] 33h shifts out identity bytes
// [R19] CCh leads to memory function commands
// [R20] lsb first, device only pulls low
module swm_dev_end #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned SAMP_CYC = swm_pkg::C_DEV_SAMP,
  parameter int unsigned HOLD_CYC = swm_pkg::C_DEV_HOLD,
  parameter int unsigned RST_CYC = swm_pkg::C_RST,
  parameter int unsigned PPD_CYC = swm_pkg::C_DEV_PPD,
  parameter int unsigned PP_CYC = swm_pkg::C_DEV_PP,
  parameter int unsigned PROG_CYC = swm_pkg::C_DEV_PROG,
  // identity values are arbitrary
  parameter logic [7:0] FAMILY = 8'hA5,
  parameter logic [47:0] SERIAL = 48'h0123456789AB,
  parameter logic [7:0] PROFILE = 8'h3C
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // link
  swm_link_if.dev lnk,
  // status
  output logic o_online,
  output logic o_prog_done
);
  typedef enum logic [3:0] {
    D_IDLE, D_ROMCMD, D_ROMSEND, D_FUNC, D_ADDR_LO, D_ADDR_HI,
    D_RDMEM, D_WRBUF, D_CRCOUT, D_PROFILE, D_PROG, D_HALT
  } swm_dstate_t;

  localparam logic [CNT_W-1:0] K_SAMP = CNT_W'(SAMP_CYC);
  localparam logic [CNT_W-1:0] K_HOLD = CNT_W'(HOLD_CYC);
  // fall is seen a cycle late and cnt starts at zero, so a low of
  // exactly the reset length still reaches this count
  localparam logic [CNT_W-1:0] K_RST = CNT_W'(RST_CYC - 2);
  localparam logic [CNT_W-1:0] K_PPD = CNT_W'(PPD_CYC);
  localparam logic [CNT_W-1:0] K_PEND = CNT_W'(PPD_CYC + PP_CYC);
  localparam logic [CNT_W-1:0] K_PROG = CNT_W'(PROG_CYC);
  localparam logic [55:0] ROM_DATA = {SERIAL, FAMILY};

  swm_dstate_t st;
  logic line_q;
  logic [CNT_W-1:0] cnt;
  logic rst_seen;
  logic pres;
  logic oe_n;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [2:0] idx;
  logic [6:0] addr;
  logic cmd_rd;
  logic [7:0] crc;
  logic sending_crc;
  logic [7:0] mem [swm_pkg::MEM_BYTES];
  logic [7:0] wbuf [swm_pkg::BUF_BYTES];

  function automatic logic [7:0] rom_at(input logic [2:0] i);
    rom_at = ROM_DATA[{i, 3'b000} +: 8];
  endfunction

  wire line = lnk.line;
  wire fall = line_q && !line;
  wire rise = !line_q && line;
  wire pres_win = (cnt >= K_PPD) && (cnt < K_PEND);
  wire pres_end = pres && (cnt == K_PEND);
  wire tx_mode = (st == D_ROMSEND) || (st == D_RDMEM) ||
                 (st == D_CRCOUT) || (st == D_PROFILE);
  wire rx_mode = (st == D_ROMCMD) || (st == D_FUNC) || (st == D_ADDR_LO) ||
                 (st == D_ADDR_HI) || (st == D_WRBUF);
  wire at_samp = !pres && !rst_seen && (cnt == K_SAMP) && (tx_mode || rx_mode);
  wire byte_end = at_samp && (bitcnt == 3'h7);
  wire [7:0] rx_byte = {line, shreg[7:1]};
  wire crc_upd = !sending_crc &&
                 ((st == D_ROMSEND) || (st == D_RDMEM) || (st == D_WRBUF));
  wire crc_in = tx_mode ? shreg[0] : line;
  wire [7:0] crc_nx = crc_upd ? swm_pkg::crc_bit(crc, crc_in) : crc; // R17
  wire [6:0] addr_inc = addr + 7'h01;
  wire [2:0] idx_inc = idx + 3'h1;
  wire prog_start = byte_end && (st == D_FUNC) &&
                    (rx_byte == swm_pkg::CMD_PROGRAM);
  wire prog_hit = (st == D_PROG) && !fall && (cnt == K_PROG);

  assign lnk.dev_out = 1'b0; // R20
  assign lnk.dev_oe_n = oe_n;

  // slot timer, reset detection and presence
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      line_q <= 1'b1;
      cnt <= '0;
      rst_seen <= 1'b0;
      pres <= 1'b0;
      oe_n <= 1'b1;
    end else if (i_clk_en) begin
      line_q <= line;
      if ((fall && !pres) || (rise && rst_seen) || prog_start) begin
        cnt <= '0;
      end else if (cnt != '1) begin
        cnt <= cnt + 1'b1;
      end
      if (!pres && !line && cnt == K_RST) begin
        rst_seen <= 1'b1; // R09
      end else if (rise && rst_seen) begin
        rst_seen <= 1'b0;
        pres <= 1'b1;
      end else if (pres_end) begin
        pres <= 1'b0;
      end
      if (pres) begin
        oe_n <= !pres_win; // R09
      end else if (fall && tx_mode && !shreg[0]) begin
        oe_n <= 1'b0; // R07
      end else if (cnt == K_HOLD || rst_seen) begin
        oe_n <= 1'b1; // R08
      end
    end
  end

  // byte engine, lsb first in both directions
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st <= D_IDLE;
      shreg <= '0;
      bitcnt <= '0;
      idx <= '0;
      addr <= '0;
      cmd_rd <= 1'b0;
      crc <= swm_pkg::CRC_INIT;
      sending_crc <= 1'b0;
      o_online <= 1'b0;
      o_prog_done <= 1'b0;
      for (int i = 0; i < swm_pkg::MEM_BYTES; i++) begin
        mem[i] <= swm_pkg::ERASED;
      end
      for (int i = 0; i < swm_pkg::BUF_BYTES; i++) begin
        wbuf[i] <= swm_pkg::ERASED;
      end
    end else if (i_clk_en) begin
      o_prog_done <= 1'b0;
      o_online <= (st != D_IDLE);
      if (rst_seen) begin
        st <= D_IDLE;
      end else if (pres_end) begin
        st <= D_ROMCMD;
        bitcnt <= '0;
        sending_crc <= 1'b0;
      end else if (st == D_PROG) begin
        // a host slot during the programming window aborts it to D_HALT with no commit
        if (fall) begin
          st <= D_HALT;
        end else if (prog_hit) begin
          for (int i = 0; i < swm_pkg::BUF_BYTES; i++) begin
            mem[{addr[6:3], 3'(i)}] <= mem[{addr[6:3], 3'(i)}] & wbuf[i]; // R15
          end
          o_prog_done <= 1'b1;
          st <= D_FUNC;
        end
      end else if (at_samp) begin
        shreg <= tx_mode ? {1'b1, shreg[7:1]} : rx_byte; // R20
        bitcnt <= bitcnt + 3'h1;
        crc <= crc_nx;
        if (byte_end) begin
          case (st)
            D_ROMCMD: begin
              if (rx_byte == swm_pkg::CMD_READ_ID) begin
                st <= D_ROMSEND; // R18
                idx <= '0;
                shreg <= rom_at(3'h0);
                crc <= swm_pkg::CRC_INIT;
              end else if (rx_byte == swm_pkg::CMD_SKIP_ID) begin
                st <= D_FUNC; // R19
              end else begin
                st <= D_HALT;
              end
            end
            D_ROMSEND: begin
              if (idx == 3'h6) begin
                shreg <= crc_nx; // R11
                sending_crc <= 1'b1;
                idx <= idx_inc;
              end else if (idx == 3'h7) begin
                st <= D_HALT;
              end else begin
                idx <= idx_inc;
                shreg <= rom_at(idx_inc); // R11
              end
            end
            D_FUNC: begin
              case (rx_byte)
                swm_pkg::CMD_READ_MEM: begin
                  st <= D_ADDR_LO;
                  cmd_rd <= 1'b1;
                end
                swm_pkg::CMD_WRITE_BUF: begin
                  st <= D_ADDR_LO;
                  cmd_rd <= 1'b0;
                end
                swm_pkg::CMD_PROGRAM: st <= D_PROG; // R15
                swm_pkg::CMD_PROFILE: begin
                  st <= D_PROFILE;
                  shreg <= PROFILE; // R16
                end
                default: st <= D_HALT;
              endcase
            end
            D_ADDR_LO: begin
              addr <= rx_byte[6:0]; // R12
              st <= D_ADDR_HI;
            end
            D_ADDR_HI: begin
              crc <= swm_pkg::CRC_INIT;
              sending_crc <= 1'b0;
              idx <= '0;
              st <= cmd_rd ? D_RDMEM : D_WRBUF;
              shreg <= mem[addr]; // R12
            end
            D_RDMEM: begin
              // crc trails each page, then the stream goes on
              if (!sending_crc && addr[4:0] == swm_pkg::PAGE_LAST) begin
                shreg <= crc_nx;
                sending_crc <= 1'b1;
              end else begin
                if (sending_crc) begin
                  crc <= swm_pkg::CRC_INIT;
                end
                sending_crc <= 1'b0;
                addr <= addr_inc;
                shreg <= mem[addr_inc];
              end
            end
            D_WRBUF: begin
              wbuf[idx] <= rx_byte; // R13
              idx <= idx_inc;
              if (idx == 3'h7) begin
                st <= D_CRCOUT;
                shreg <= crc_nx; // R14
              end
            end
            D_CRCOUT: st <= D_FUNC;
            D_PROFILE: st <= D_FUNC;
            default: st <= D_HALT;
          endcase
        end
      end
    end
  end
endmodule

// file: src/swm_host_end.sv
module swm_host_end #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned RST_CYC = swm_pkg::C_RST,
  parameter int unsigned RSTREC_CYC = swm_pkg::C_RSTREC,
  parameter int unsigned PSAMP_CYC = swm_pkg::C_HOST_PSAMP,
  parameter int unsigned SLOT_CYC = swm_pkg::C_HOST_SLOT,
  parameter int unsigned WL1_CYC = swm_pkg::C_HOST_WL1,
  parameter int unsigned WL0_CYC = swm_pkg::C_HOST_WL0,
  parameter int unsigned RL_CYC = swm_pkg::C_HOST_RL,
  parameter int unsigned RSAMP_CYC = swm_pkg::C_HOST_RSAMP,
  parameter int unsigned PROG_CYC = swm_pkg::C_HOST_PROG
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // link
  swm_link_if.host lnk,
  // command request
  input wire logic i_cmd_valid,
  input wire swm_pkg::swm_hcmd_t i_cmd,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  // received bytes
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  // status
  output logic o_presence,
  output logic [7:0] o_rx_crc
);
  typedef enum logic [2:0] {
    H_IDLE, H_RST_LOW, H_RST_REC, H_SLOT, H_PROG
  } swm_hstate_t;

  localparam logic [CNT_W-1:0] K_RST = CNT_W'(RST_CYC - 1);
  localparam logic [CNT_W-1:0] K_RSTREC = CNT_W'(RSTREC_CYC - 1);
  localparam logic [CNT_W-1:0] K_PSAMP = CNT_W'(PSAMP_CYC);
  localparam logic [CNT_W-1:0] K_SLOT = CNT_W'(SLOT_CYC - 1);
  localparam logic [CNT_W-1:0] K_WL1 = CNT_W'(WL1_CYC - 1);
  localparam logic [CNT_W-1:0] K_WL0 = CNT_W'(WL0_CYC - 1);
  localparam logic [CNT_W-1:0] K_RL = CNT_W'(RL_CYC - 1);
  localparam logic [CNT_W-1:0] K_RSAMP = CNT_W'(RSAMP_CYC);
  localparam logic [CNT_W-1:0] K_PROG = CNT_W'(PROG_CYC - 1);

  swm_hstate_t st;
  swm_pkg::swm_hcmd_t op;
  logic [CNT_W-1:0] cnt;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic oe_n;
  logic [7:0] skid;
  logic skid_v;

  wire line = lnk.line;
  wire is_read = (op == swm_pkg::HC_READ);
  wire accept = i_cmd_valid && o_cmd_ready;
  // R02 R03 R04 R06: start low per slot kind
  wire [CNT_W-1:0] low_end = is_read ? K_RL : (shreg[0] ? K_WL1 : K_WL0);
  wire slot_end = (st == H_SLOT) && (cnt == K_SLOT);
  wire last_bit = (bitcnt == 3'h7);
  wire push = slot_end && last_bit && is_read;
  wire pop = o_rx_valid && i_rx_ready;

  assign lnk.host_out = 1'b0;
  assign lnk.host_oe_n = oe_n;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st <= H_IDLE;
      op <= swm_pkg::HC_RESET;
      cnt <= '0;
      shreg <= '0;
      bitcnt <= '0;
      oe_n <= 1'b1;
      o_cmd_ready <= 1'b0;
      o_presence <= 1'b0;
      o_rx_crc <= swm_pkg::CRC_INIT;
    end else if (i_clk_en) begin
      // a full buffer holds off new commands, so no read byte is lost
      o_cmd_ready <= (st == H_IDLE) && !accept && !skid_v;
      cnt <= cnt + 1'b1;
      case (st)
        H_IDLE: begin
          cnt <= '0;
          if (accept) begin
            op <= i_cmd;
            shreg <= i_cmd_data;
            bitcnt <= '0;
            case (i_cmd)
              swm_pkg::HC_RESET: begin
                st <= H_RST_LOW;
                oe_n <= 1'b0;
                o_rx_crc <= swm_pkg::CRC_INIT;
              end
              swm_pkg::HC_WRITE: begin
                st <= H_SLOT;
                oe_n <= 1'b0;
                o_rx_crc <= swm_pkg::CRC_INIT;
              end
              swm_pkg::HC_READ: begin
                st <= H_SLOT;
                oe_n <= 1'b0;
              end
              default: st <= H_PROG; // R10
            endcase
          end
        end
        H_RST_LOW: begin
          if (cnt == K_RST) begin
            oe_n <= 1'b1; // R09
            cnt <= '0;
            st <= H_RST_REC;
          end
        end
        H_RST_REC: begin
          if (cnt == K_PSAMP) begin
            o_presence <= !line; // R09
          end
          if (cnt == K_RSTREC) begin
            st <= H_IDLE;
          end
        end
        H_SLOT: begin
          if (cnt == low_end) begin
            oe_n <= 1'b1; // R05
          end
          if (is_read && cnt == K_RSAMP) begin
            shreg <= {line, shreg[7:1]}; // R20
            o_rx_crc <= swm_pkg::crc_bit(o_rx_crc, line); // R17
          end
          if (slot_end) begin
            cnt <= '0; // R01
            if (!is_read) begin
              shreg <= {1'b0, shreg[7:1]};
            end
            if (last_bit) begin
              st <= H_IDLE;
            end else begin
              bitcnt <= bitcnt + 3'h1;
              oe_n <= 1'b0;
            end
          end
        end
        H_PROG: begin
          if (cnt == K_PROG) begin
            st <= H_IDLE; // R10
          end
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // two-entry buffer: output register plus one skid entry
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= '0;
      skid <= '0;
      skid_v <= 1'b0;
    end else if (i_clk_en) begin
      if (pop) begin
        if (skid_v) begin
          o_rx_data <= skid;
          skid_v <= push;
          skid <= push ? shreg : skid;
        end else if (push) begin
          o_rx_data <= shreg;
        end else begin
          o_rx_valid <= 1'b0;
        end
      end else if (push) begin
        if (!o_rx_valid) begin
          o_rx_valid <= 1'b1;
          o_rx_data <= shreg;
        end else begin
          skid_v <= 1'b1;
          skid <= shreg;
        end
      end
    end
  end
endmodule

// file: tb/swm_link_asserts.sv
module swm_link_asserts #(
  parameter int unsigned US = swm_pkg::CLK_MHZ
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // link wire and drivers
  input wire logic line,
  input wire logic dev_out,
  input wire logic dev_oe_n,
  input wire logic host_out,
  input wire logic host_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] slot_cnt, hi_cnt, host_cnt, dev_cnt;
  logic line_q, dev_q, host_q, pres, act, rst_seen;
  wire logic line_fall;
  wire logic dev_fall;
  wire logic rst_end;
  assign line_fall = line_q & ~line;
  assign dev_fall = dev_q & ~dev_oe_n;
  assign rst_end = ~host_q & host_oe_n & (host_cnt >= 480 * US);
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      {slot_cnt, hi_cnt, host_cnt, dev_cnt} <= '0;
      {line_q, dev_q, host_q} <= 3'b111;
      {pres, act, rst_seen} <= 3'b000;
    end else begin
      slot_cnt <= line_fall ? 32'h1 : slot_cnt + 32'h1;
      hi_cnt <= line ? hi_cnt + 32'h1 : '0;
      host_cnt <= host_oe_n ? '0 : host_cnt + 32'h1;
      dev_cnt <= dev_oe_n ? '0 : dev_cnt + 32'h1;
      {line_q, dev_q, host_q} <= {line, dev_oe_n, host_oe_n};
      pres <= dev_fall ? line_q : pres;
      act <= act | line_fall;
      // first fall after reset has no previous slot to measure against
      rst_seen <= rst_end ? 1'b1 : (dev_fall ? 1'b0 : rst_seen);
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_bit_start;
    dev_fall && !line_q;
  endsequence
  sequence s_pres_start;
    dev_fall && line_q;
  endsequence
  chk_open_drain: assert property (!dev_out && !host_out)
    else $error("driver output not low");
  chk_bit_delay: assert property (s_bit_start |-> slot_cnt <= 13 * US)
    else $error("read bit driven late");
  chk_bit_hold: assert property ($rose(dev_oe_n) && !pres |->
    slot_cnt >= 17 * US && slot_cnt <= 60 * US)
    else $error("read bit hold out of range");
  chk_pres_delay: assert property (s_pres_start |->
    hi_cnt >= 15 * US && hi_cnt <= 60 * US)
    else $error("presence delay out of range");
  chk_pres_width: assert property ($rose(dev_oe_n) && pres |->
    dev_cnt >= 60 * US && dev_cnt <= 240 * US)
    else $error("presence width out of range");
  chk_pres_due: assert property (rst_seen |-> hi_cnt <= 60 * US)
    else $error("presence missing after reset");
  chk_slot_len: assert property (act && line_fall &&
    slot_cnt <= 120 * US |-> slot_cnt >= 60 * US)
    else $error("bit slot too short");
  chk_strobe_len: assert property ($rose(host_oe_n) |->
    (host_cnt >= US && host_cnt <= 15 * US) ||
    (host_cnt >= 60 * US && host_cnt < 120 * US) || host_cnt >= 480 * US)
    else $error("host low time out of range");
  chk_recovery: assert property ($fell(host_oe_n) && act |->
    hi_cnt >= 5 * US)
    else $error("recovery too short");
endmodule

// file: tb/swm_link_tb_top.sv
module swm_link_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // two cycles a microsecond keeps the run short; all counts scale alike
  localparam int unsigned US = 2;
  localparam logic [7:0] FAM = 8'h5E; // arbitrary value
  localparam logic [47:0] SER = 48'h31A7C2E90B64; // arbitrary value
  localparam logic [7:0] PROF = 8'h4B; // arbitrary value
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  swm_pkg::swm_hcmd_t cmd = swm_pkg::HC_RESET;
  logic [7:0] cmd_data = 8'h00;
  logic rx_ready = 1'b0;
  wire logic cmd_ready, rx_valid, presence, online, prog_done;
  wire logic [7:0] rx_data, rx_crc;
  int fails = 0;
  int checked = 0;
  int seed = 3818;
  int n, pd, low_len;
  logic [7:0] idb [8];
  logic [7:0] dat [8];
  logic [7:0] b, crc, wire_byte;
  logic [6:0] addr;
  always #2 i_sys_clk = ~i_sys_clk;
  swm_link_if swm_link_if_i();
  swm_dev_end #(.SAMP_CYC(swm_pkg::T_DEV_SAMP_US * US),
    .HOLD_CYC(swm_pkg::T_DEV_HOLD_US * US), .RST_CYC(480 * US),
    .PPD_CYC(swm_pkg::T_DEV_PPD_US * US), .PP_CYC(swm_pkg::T_DEV_PP_US * US),
    .PROG_CYC(2505 * US), .FAMILY(FAM), .SERIAL(SER), .PROFILE(PROF))
  swm_dev_end_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_clk_en(1'b1), .lnk(swm_link_if_i.dev), .o_online(online),
    .o_prog_done(prog_done));
  swm_host_end #(.RST_CYC(480 * US), .RSTREC_CYC(480 * US),
    .PSAMP_CYC(70 * US), .SLOT_CYC(70 * US), .WL1_CYC(5 * US),
    .WL0_CYC(65 * US), .RL_CYC(2 * US), .RSAMP_CYC(10 * US),
    .PROG_CYC(2510 * US))
  swm_host_end_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_clk_en(1'b1), .lnk(swm_link_if_i.host), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
    .o_presence(presence), .o_rx_crc(rx_crc));
  swm_link_asserts #(.US(US)) swm_link_asserts_i (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .line(swm_link_if_i.line),
    .dev_out(swm_link_if_i.dev_out), .dev_oe_n(swm_link_if_i.dev_oe_n),
    .host_out(swm_link_if_i.host_out), .host_oe_n(swm_link_if_i.host_oe_n));
  // wire decoder: short low is a one, long low a zero, lsb arrives first
  always @(posedge i_sys_clk) begin
    if (swm_link_if_i.host_oe_n === 1'b0) begin
      low_len <= low_len + 1;
    end else begin
      if (low_len > 0 && low_len < 120 * US) begin
        wire_byte <= {low_len < 15 * US, wire_byte[7:1]};
      end
      low_len <= 0;
    end
  end
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction
  task automatic step();
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_ready(int lim);
    n = 0;
    while (cmd_ready !== 1'b1 && n < lim) begin
      step();
      n++;
    end
    if (n >= lim) check("cmd ready", cmd_ready, 8'h01);
  endtask
  task automatic send(swm_pkg::swm_hcmd_t k, logic [7:0] d);
    wait_ready(6000);
    cmd_valid = 1'b1;
    cmd = k;
    cmd_data = d;
    step();
    cmd_valid = 1'b0;
  endtask
  task automatic pop(output logic [7:0] v);
    n = 0;
    while (rx_valid !== 1'b1 && n < 2000) begin
      step();
      n++;
    end
    if (n >= 2000) check("rx valid", rx_valid, 8'h01);
    v = rx_data;
    rx_ready = 1'b1;
    step();
    rx_ready = 1'b0;
    step();
  endtask
  task automatic rd(output logic [7:0] v);
    send(swm_pkg::HC_READ, 8'h00);
    pop(v);
  endtask
  task automatic link_reset();
    send(swm_pkg::HC_RESET, 8'h00);
    wait_ready(3000);
    check("presence", presence, 8'h01);
    check("online", online, 8'h01);
    check("line idle", swm_link_if_i.line, 8'h01);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge i_sys_clk);
    fails++;
    $display("MISMATCH watchdog expected done seen hang");
    give_verdict();
  end
  initial begin
    step();
    step();
    i_sys_rst = 1'b0;
    idb[0] = FAM;
    crc = crc8(8'h00, FAM);
    for (int j = 1; j < 7; j++) begin
      idb[j] = SER[8 * j - 8 +: 8];
      crc = crc8(crc, idb[j]);
    end
    idb[7] = crc;
    link_reset();
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_READ_ID);
    // two reads unpopped: buffer must refuse further commands
    for (int k = 0; k < 8; k += 2) begin
      send(swm_pkg::HC_READ, 8'h00);
      send(swm_pkg::HC_READ, 8'h00);
      repeat (9 * 70 * US) step();
      check("full stall", cmd_ready, 8'h00);
      pop(b);
      check("id byte", b, idb[k]);
      pop(b);
      check("id byte", b, idb[k + 1]);
    end
    check("rx crc", rx_crc, 8'h00);
    $display("test identity done");
    link_reset();
    addr = 7'($random(seed)) & 7'h78;
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_SKIP_ID);
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_WRITE_BUF);
    send(swm_pkg::HC_WRITE, {1'b0, addr});
    send(swm_pkg::HC_WRITE, 8'h00);
    crc = 8'h00;
    for (int k = 0; k < 8; k++) begin
      dat[k] = (k == 0) ? 8'h00 : 8'($random(seed));
      crc = crc8(crc, dat[k]);
      send(swm_pkg::HC_WRITE, dat[k]);
    end
    rd(b);
    check("buffer crc", b, crc);
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_PROGRAM);
    send(swm_pkg::HC_PROG, 8'h00);
    n = 0;
    pd = 0;
    while (cmd_ready !== 1'b1 && n < 6000) begin
      if (prog_done === 1'b1) pd = n;
      step();
      n++;
    end
    check("prog pulse", 8'(pd > 0), 8'h01);
    check("prog hold", 8'(n >= 2510 * US), 8'h01);
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_READ_MEM);
    send(swm_pkg::HC_WRITE, {1'b0, addr});
    send(swm_pkg::HC_WRITE, 8'h00);
    for (int k = 0; k < 8; k++) begin
      rd(b);
      check("mem byte", b, dat[k]);
    end
    rd(b);
    if (addr[4:0] != 5'h18) begin
      check("next erased", b, swm_pkg::ERASED);
    end else begin
      check("page crc", b, crc);
    end
    $display("test program done");
    link_reset();
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_SKIP_ID);
    wait_ready(2000);
    check("wire byte", wire_byte, swm_pkg::CMD_SKIP_ID);
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_PROFILE);
    rd(b);
    check("profile", b, PROF);
    link_reset();
    send(swm_pkg::HC_WRITE, swm_pkg::CMD_SKIP_ID);
    send(swm_pkg::HC_WRITE, 8'h11);
    rd(b);
    check("halted", b, 8'hFF);
    $display("test functions done");
    // reset in mid-slot must release the wire and clear status
    send(swm_pkg::HC_WRITE, 8'h00);
    repeat (50) step();
    i_sys_rst = 1'b1;
    step();
    step();
    check("ready in reset", cmd_ready, 8'h00);
    check("presence reset", presence, 8'h00);
    check("online reset", online, 8'h00);
    check("line released", swm_link_if_i.line, 8'h01);
    i_sys_rst = 1'b0;
    link_reset();
    $display("test mid reset done");
    give_verdict();
  end
endmodule
